// *** dv/test_cst_call_stack.sv ***
// self-checking testbench for the return stack and table read block
`timescale 1ns/1ps

module test_cst_call_stack;
  import cst_pkg::*;

  logic              clock;
  logic              rst_b;
  cst_cmd_t          cmd;
  logic              int_event;
  logic              int_en;
  cst_pm_wr_t        pm_wr;
  logic              cyc_en;
  logic              busy;
  logic [9:0]        pc;
  logic [7:0]        pc_low_byte;
  logic [15:0]       instr;
  cst_tbl_wr_t       tbl_wr;
  logic [7:0]        table_high_byte_latch;
  logic              int_ack;
  logic              int_flag;
  logic              stack_full;
  int                fails;
  int                total_checks;
  int                acks;
  int                cycles;
  logic [9:0]        saved_pc;
  logic [9:0]        back_pc [0:4];

  cst_call_stack u_dut (
    .clock                 (clock),
    .rst_b                 (rst_b),
    .cmd                   (cmd),
    .int_event             (int_event),
    .int_en                (int_en),
    .pm_wr                 (pm_wr),
    .cyc_en                (cyc_en),
    .busy                  (busy),
    .pc                    (pc),
    .pc_low_byte           (pc_low_byte),
    .instr                 (instr),
    .tbl_wr                (tbl_wr),
    .table_high_byte_latch (table_high_byte_latch),
    .int_ack               (int_ack),
    .int_flag              (int_flag),
    .stack_full            (stack_full)
  );

  //////////////////////////////////////////////////////////////////////////
  // clock, acknowledge counter and hang guard
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // the run needs a few hundred cycles; the ceiling leaves ample margin
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (int_ack === 1'b1) acks <= acks + 1;
    if (cycles == 20000) begin
      fails = fails + 1;
      conclude();
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // shared tasks
  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
    total_checks = total_checks + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // negedge just before an edge that will take a command
  task automatic wait_slot();
    do @(negedge clock); while (cyc_en !== 1'b1 || busy !== 1'b0);
  endtask

  // one command, held for the one clock that takes it, then back to no operation
  task automatic issue(cst_op_t o, logic [9:0] t, logic [7:0] d,
                       logic [7:0] m);
    wait_slot();
    saved_pc = pc;
    cmd = '{op: o, target: t, data: d, dest: m};
    @(negedge clock);
    cmd.op = CST_OP_NONE;
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    check("pc after reset", 16'h0000, {6'h00, pc});
    check("full after reset", 16'h0000, {15'h0000, stack_full});
    check("flag after reset", 16'h0000, {15'h0000, int_flag});
    check("latch after reset", 16'h0000,
          {8'h00, table_high_byte_latch});
    wait_slot();
    @(negedge clock);
    check("first fetch", 16'hA55A, instr);
    check("pc after fetch", 16'h0001, {6'h00, pc});
    $display("test reset done");
  endtask

  // call then return, with a page-limited low byte write in between
  task automatic t_call_return();
    logic [9:0] back;
    issue(CST_OP_CALL, 10'h1F0, 8'h00, 8'h00);
    back = saved_pc;
    check("call busy", 16'h0001, {15'h0000, busy});
    wait_slot();
    check("call target", 16'h01F1, {6'h00, pc});
    issue(CST_OP_WR_PC_LOW_BYTE, 10'h000, 8'h22, 8'h00);
    wait_slot();
    check("pc low jump", 16'h0123, {6'h00, pc});
    check("pc low byte", 16'h0023, {8'h00, pc_low_byte});
    issue(CST_OP_RETURN_FROM_SUBROUTINE, 10'h000, 8'h00, 8'h00);
    wait_slot();
    check("return pc", {6'h00, back + 10'h001}, {6'h00, pc});
    $display("test call_return done");
  endtask

  // five calls on a four-level stack: the first saved value is lost
  task automatic t_overflow();
    for (int i = 0; i < 5; i++) begin
      issue(CST_OP_CALL, 10'(10'h080 + 10'(i * 16)), 8'h00, 8'h00);
      back_pc[i] = saved_pc;
      wait_slot();
      check("full level", {15'h0000, 1'(i >= 3)},
            {15'h0000, stack_full});
    end
    for (int i = 4; i > 0; i--) begin
      issue(CST_OP_RETURN_FROM_SUBROUTINE, 10'h000, 8'h00, 8'h00);
      wait_slot();
      check("overflow pop", {6'h00, back_pc[i] + 10'h001}, {6'h00, pc});
    end
    check("empty again", 16'h0000, {15'h0000, stack_full});
    $display("test overflow done");
  endtask

  // interrupt held off by a full stack, taken after a return frees a level
  task automatic t_int_full();
    int_en = 1'b1;
    for (int i = 0; i < 4; i++) issue(CST_OP_CALL, 10'h040, 8'h00, 8'h00);
    wait_slot();
    int_event = 1'b1;
    @(negedge clock);
    int_event = 1'b0;
    repeat (3) wait_slot();
    check("flag held", 16'h0001, {15'h0000, int_flag});
    check("no ack full", 16'h0000, 16'(acks));
    issue(CST_OP_RETURN_FROM_SUBROUTINE, 10'h000, 8'h00, 8'h00);
    // look at the pulse between edges, where it has settled
    repeat (16) begin
      @(negedge clock);
      if (int_ack === 1'b1) break;
    end
    check("ack pulse", 16'h0001, {15'h0000, int_ack});
    check("int vector", {6'h00, INT_VEC}, {6'h00, pc});
    check("flag cleared", 16'h0000, {15'h0000, int_flag});
    check("ack pushed", 16'h0001, {15'h0000, stack_full});
    @(negedge clock);
    check("ack after return", 16'h0001, 16'(acks));
    check("ack one clock", 16'h0000, {15'h0000, int_ack});
    int_en = 1'b0;
    issue(CST_OP_RETURN_FROM_INTERRUPT, 10'h000, 8'h00, 8'h00);
    wait_slot();
    check("interrupt return pop", 16'h0000, {15'h0000, stack_full});
    for (int i = 0; i < 3; i++) begin
      issue(CST_OP_RETURN_FROM_SUBROUTINE, 10'h000, 8'h00, 8'h00);
    end
    $display("test int_full done");
  endtask

  // table read from both pointers, then from the last page
  task automatic t_table();
    issue(CST_OP_SET_TBLP, 10'h000, 8'h06, 8'h00);
    issue(CST_OP_SET_TBHP, 10'h000, 8'h02, 8'h00);
    for (int k = 0; k < 2; k++) begin
      issue(k == 0 ? CST_OP_TABRD : CST_OP_TABLE_READ_LAST_PAGE, 10'h000,
            8'h00, 8'(8'h61 + k));
      check("table busy", 16'h0001, {15'h0000, busy});
      repeat (4) @(negedge clock);
      check("table we", 16'h0001, {15'h0000, tbl_wr.we});
      check("table dest", {8'h00, 8'(8'h61 + k)},
            {8'h00, tbl_wr.addr});
      check("table low", k == 0 ? 16'h00EF : 16'h002B,
            {8'h00, tbl_wr.data});
      check("table high", k == 0 ? 16'h00BE : 16'h001A,
            {8'h00, table_high_byte_latch});
      @(negedge clock);
      check("we one clock", 16'h0000, {15'h0000, tbl_wr.we});
    end
    $display("test table done");
  endtask

  //////////////////////////////////////////////////////////////////////////
  // main sequence: reset with program words loaded meanwhile
  initial begin
    fails = 0;
    total_checks = 0;
    acks = 0;
    cycles = 0;
    rst_b = 1'b0;
    cmd = '{op: CST_OP_NONE, target: 10'h000, data: 8'h00, dest: 8'h00};
    int_event = 1'b0;
    int_en = 1'b0;
    pm_wr = '{en: 1'b0, addr: 10'h000, data: 16'h0000};
    @(negedge clock);
    pm_wr = '{en: 1'b1, addr: 10'h000, data: 16'hA55A};
    @(negedge clock);
    pm_wr = '{en: 1'b1, addr: 10'h206, data: 16'hBEEF};
    @(negedge clock);
    pm_wr = '{en: 1'b1, addr: 10'h306, data: 16'h1A2B};
    @(negedge clock);
    pm_wr.en = 1'b0;
    rst_b = 1'b1;
    @(negedge clock);
    t_reset();
    t_call_return();
    t_overflow();
    t_int_full();
    t_table();
    conclude();
  end

endmodule // test_cst_call_stack

// *** hdl/cst_call_stack.sv ***
// return stack, program counter, program memory and table read path
`timescale 1ns/1ps

module cst_call_stack (
  input  wire logic                 clock,
  input  wire logic                 rst_b,
  input  wire cst_pkg::cst_cmd_t    cmd,
  input  wire logic                 int_event,
  input  wire logic                 int_en,
  input  wire cst_pkg::cst_pm_wr_t  pm_wr,
  output logic                      cyc_en,
  output logic                      busy,
  output logic [9:0]                pc,
  output logic [7:0]                pc_low_byte,
  output logic [15:0]               instr,
  output cst_pkg::cst_tbl_wr_t      tbl_wr,
  output logic [7:0]                table_high_byte_latch,
  output logic                      int_ack,
  output logic                      int_flag,
  output logic                      stack_full
);
  import cst_pkg::*;

  logic [1:0]        ph_r;
  logic [9:0]        pc_r;
  logic [15:0]       instr_r;
  logic              dummy_r;
  logic [9:0]        stk_r [STK_DEPTH];
  logic [1:0]        top_r;
  logic [2:0]        depth_r;
  logic [15:0]       pm_r [PM_DEPTH];
  logic [7:0]        tblp_r;
  logic [1:0]        tbhp_r;
  logic [7:0]        latch_r;
  logic [9:0]        tbl_addr_r;
  logic [7:0]        tbl_dest_r;
  logic              tbl_pend_r;
  cst_tbl_wr_t       tbl_wr_r;
  logic              int_flag_r;
  logic              int_ack_r;
  logic              exec;
  logic              take_int;
  logic              push;
  logic              pop;
  logic              full;
  logic [15:0]       tbl_word;

  // wrap-around step of the two-bit stack index
  function automatic logic [1:0] idx_step(input logic [1:0] i,
                                          input logic       up);
    idx_step = up ? 2'(i + 2'h1) : 2'(i - 2'h1);
  endfunction

  // next sequential program address
  function automatic logic [9:0] pc_inc(input logic [9:0] p);
    pc_inc = 10'(p + 10'h001);
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // instruction cycle divider: one enable pulse per T1..T4 group
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      ph_r <= 2'h0;
    end else begin
      ph_r <= (ph_r == PH_LAST) ? 2'h0 : 2'(ph_r + 2'h1);
    end
  end

  assign cyc_en = (ph_r == PH_LAST);

  //////////////////////////////////////////////////////////////////////////
  // decode of the current cycle; second cycles of branches and table
  // reads swallow whatever the decoder presents
  assign busy     = dummy_r | tbl_pend_r;
  assign exec     = cyc_en & ~busy;
  assign full     = (depth_r == STK_FULL);
  // an acknowledge only lands on an idle slot, so it never
  // collides with a call or return in the same cycle
  assign take_int = exec & (cmd.op == CST_OP_NONE) & int_flag_r
                    & int_en & ~full;
  assign push     = take_int | (exec & (cmd.op == CST_OP_CALL));
  assign pop      = exec & ((cmd.op == CST_OP_RETURN_FROM_SUBROUTINE) |
                            (cmd.op == CST_OP_RETURN_FROM_INTERRUPT));

  //////////////////////////////////////////////////////////////////////////
  // program counter; reset lands on the reset vector
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      pc_r <= RESET_VEC;
    end else if (take_int) begin
      pc_r <= INT_VEC;
    end else if (exec) begin
      case (cmd.op)
        CST_OP_JUMP,
        CST_OP_CALL:   pc_r <= cmd.target;
        CST_OP_RETURN_FROM_SUBROUTINE,
        CST_OP_RETURN_FROM_INTERRUPT:
          pc_r <= stk_r[top_r];
        CST_OP_WR_PC_LOW_BYTE:
          pc_r <= {pc_r[9:8], cmd.data};
        default:       pc_r <= pc_inc(pc_r);
      endcase
    end else if (cyc_en && dummy_r) begin
      pc_r <= pc_inc(pc_r);   // dummy slot fetches the branch target
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // one dummy cycle after any change of flow, for the refetch
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      dummy_r <= 1'b0;
    end else if (cyc_en) begin
      dummy_r <= take_int |
                 (exec & (cmd.op inside {CST_OP_JUMP, CST_OP_CALL,
                                         CST_OP_RETURN_FROM_SUBROUTINE,
                                         CST_OP_RETURN_FROM_INTERRUPT,
                                         CST_OP_WR_PC_LOW_BYTE}));
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // instruction fetch from program memory
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      instr_r <= 16'h0000;
    end else if (cyc_en && !tbl_pend_r) begin
      instr_r <= pm_r[pc_r];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // program memory, 1K x 16; only the load port writes it
  always_ff @(posedge clock) begin
    if (pm_wr.en) begin
      pm_r[pm_wr.addr] <= pm_wr.data;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // return stack as a ring: a push on a full stack overwrites the
  // oldest entry, which is exactly the one an overflow loses
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      top_r   <= STK_TOP_RST;
      depth_r <= STK_EMPTY;
      for (int i = 0; i < STK_DEPTH; i++) begin
        stk_r[i] <= RESET_VEC;
      end
    end else if (push) begin
      stk_r[idx_step(top_r, 1'b1)] <= pc_r;
      top_r   <= idx_step(top_r, 1'b1);
      depth_r <= full ? STK_FULL : 3'(depth_r + 3'h1);
    end else if (pop) begin
      top_r   <= idx_step(top_r, 1'b0);
      depth_r <= (depth_r == STK_EMPTY) ? STK_EMPTY
                                        : 3'(depth_r - 3'h1);
    end
  end

  // no port exposes stk_r, top_r or depth_r contents
  assign stack_full = full;

  //////////////////////////////////////////////////////////////////////////
  // interrupt request flag: a new event beats the clear by acknowledge
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      int_flag_r <= 1'b0;
    end else if (int_event) begin
      int_flag_r <= 1'b1;
    end else if (take_int) begin
      int_flag_r <= 1'b0;
    end
  end

  // acknowledge pulse, one clock wide
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      int_ack_r <= 1'b0;
    end else begin
      int_ack_r <= take_int;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // table pointers, written by the decoder on behalf of software
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      tblp_r <= TBLP_RST;
      tbhp_r <= TBHP_RST;
    end else if (exec) begin
      if (cmd.op == CST_OP_SET_TBLP) begin
        tblp_r <= cmd.data;
      end
      if (cmd.op == CST_OP_SET_TBHP) begin
        tbhp_r <= cmd.data[1:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // table read, first cycle: form the address and hold the operand
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      tbl_pend_r <= 1'b0;
      tbl_addr_r <= RESET_VEC;
      tbl_dest_r <= 8'h00;
    end else if (exec && cmd.op == CST_OP_TABRD) begin
      tbl_pend_r <= 1'b1;
      tbl_addr_r <= {tbhp_r, tblp_r};
      tbl_dest_r <= cmd.dest;
    end else if (exec && cmd.op == CST_OP_TABLE_READ_LAST_PAGE) begin
      tbl_pend_r <= 1'b1;
      tbl_addr_r <= {LAST_PAGE, tblp_r};
      tbl_dest_r <= cmd.dest;
    end else if (cyc_en) begin
      tbl_pend_r <= 1'b0;   // second cycle ends the read
    end
  end

  assign tbl_word = pm_r[tbl_addr_r];

  //////////////////////////////////////////////////////////////////////////
  // table read, second cycle: low byte to data memory, high byte to
  // the latch; the word is full width so no latch bit is forced to 0
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      tbl_wr_r <= '0;
      latch_r  <= LATCH_RST;
    end else if (cyc_en && tbl_pend_r) begin
      tbl_wr_r <= '{we: 1'b1, addr: tbl_dest_r,
                    data: tbl_word[7:0]};
      latch_r  <= tbl_word[15:8];
    end else begin
      tbl_wr_r.we <= 1'b0;
    end
  end

  // the latch has only this read port; an interrupt routine that
  // reads a table clobbers it and nothing can put it back
  assign table_high_byte_latch = latch_r;

  //////////////////////////////////////////////////////////////////////////
  // outputs
  assign pc          = pc_r;
  assign pc_low_byte = pc_r[7:0];
  assign instr       = instr_r;
  assign tbl_wr      = tbl_wr_r;
  assign int_ack     = int_ack_r;
  assign int_flag    = int_flag_r;

  //////////////////////////////////////////////////////////////////////////
  // checks
  logic [9:0] top_val;
  assign top_val = stk_r[top_r];

  AST_RESET_EMPTY: assert property (
    @(posedge clock) !rst_b |=> (depth_r == STK_EMPTY) && (pc_r == RESET_VEC)
  ) else $error("reset did not empty stack or clear pc");

  AST_CALL_PUSH: assert property (
    @(posedge clock) disable iff (!rst_b)
    (exec && cmd.op == CST_OP_CALL && !full)
    |=> depth_r == 3'($past(depth_r) + 3'h1) && top_val == $past(pc_r)
  ) else $error("call did not push pc");

  AST_RET_POP: assert property (
    @(posedge clock) disable iff (!rst_b)
    pop |=> pc_r == $past(top_val)
  ) else $error("return did not restore pc from stack");

  AST_FULL_NO_ACK: assert property (
    @(posedge clock) disable iff (!rst_b)
    full |=> !int_ack_r
  ) else $error("acknowledge given with full stack");

  AST_FLAG_KEPT: assert property (
    @(posedge clock) disable iff (!rst_b)
    (int_event && full) |=> int_flag_r [*4]
  ) else $error("flag lost while stack full");

  AST_HELD_SERVICED: assert property (
    @(posedge clock) disable iff (!rst_b)
    (pop && full && int_flag_r && int_en && !int_event)
    ##8 (cyc_en && !busy && cmd.op == CST_OP_NONE && int_en)
    |=> int_ack_r && pc_r == INT_VEC
  ) else $error("held interrupt not serviced after return");

  AST_OVERFLOW: assert property (
    @(posedge clock) disable iff (!rst_b)
    (push && full) |=> full && top_val == $past(pc_r)
  ) else $error("call on full stack misbehaved");

  AST_TBL_TWO_CYC: assert property (
    @(posedge clock) disable iff (!rst_b)
    (exec && cmd.op inside {CST_OP_TABRD, CST_OP_TABLE_READ_LAST_PAGE})
    |=> !tbl_wr_r.we [*4] ##1 tbl_wr_r.we
  ) else $error("table read did not finish in two cycles");

  AST_LAST_PAGE: assert property (
    @(posedge clock) disable iff (!rst_b)
    (exec && cmd.op == CST_OP_TABLE_READ_LAST_PAGE)
    |=> tbl_addr_r == {LAST_PAGE, $past(tblp_r)}
  ) else $error("last page table address wrong");

  AST_PC_LOW_PAGE: assert property (
    @(posedge clock) disable iff (!rst_b)
    (exec && cmd.op == CST_OP_WR_PC_LOW_BYTE)
    |=> pc_r == {$past(pc_r[9:8]), $past(cmd.data)}
  ) else $error("pc low write left the page");

  // acknowledge saves the counter and enters the vector in one step
  AST_ACK_PUSH: assert property (
    @(posedge clock) disable iff (!rst_b)
    take_int |=> top_val == $past(pc_r) && pc_r == INT_VEC
  ) else $error("acknowledge did not push pc");

  AST_FLAG_SET: assert property (
    @(posedge clock) disable iff (!rst_b)
    int_event |=> int_flag_r
  ) else $error("interrupt event did not set flag");

  // second table cycle routes both halves of the addressed word
  AST_TBL_BYTES: assert property (
    @(posedge clock) disable iff (!rst_b)
    (cyc_en && tbl_pend_r)
    |=> tbl_wr_r.we && tbl_wr_r.addr == $past(tbl_dest_r)
        && tbl_wr_r.data == $past(tbl_word[7:0])
        && latch_r == $past(tbl_word[15:8])
  ) else $error("table read bytes misrouted");

endmodule // cst_call_stack

// *** hdl/cst_pkg.sv ***
// package: constants, opcodes and carriers for the call stack block
package cst_pkg;

  // instruction cycle: four clocks (T1..T4) per instruction
  localparam int          INSTR_CLKS  = 4;
  localparam logic [1:0]  PH_LAST     = 2'(INSTR_CLKS - 1);

  // program memory shape
  localparam int          PC_W        = 10;
  localparam int          PM_DEPTH    = 1024;
  localparam int          PM_W        = 16;
  localparam int          BYTE_W      = 8;

  // fixed vectors; the interrupt entry is a plain default
  localparam logic [9:0]  RESET_VEC   = 10'h000;
  localparam logic [9:0]  INT_VEC     = 10'h004;
  localparam logic [1:0]  LAST_PAGE   = 2'h3;   // word 300h and up

  // return stack
  localparam int          STK_DEPTH   = 4;
  localparam logic [2:0]  STK_FULL    = 3'h4;
  localparam logic [2:0]  STK_EMPTY   = 3'h0;
  localparam logic [1:0]  STK_TOP_RST = 2'h0;

  // reset values of the pointer and latch registers
  localparam logic [7:0]  TBLP_RST    = 8'h00;
  localparam logic [1:0]  TBHP_RST    = 2'h0;
  localparam logic [7:0]  LATCH_RST   = 8'h00;

  // operations handed over by the instruction decoder
  typedef enum logic [3:0] {
    CST_OP_NONE,
    CST_OP_JUMP,
    CST_OP_CALL,
    CST_OP_RETURN_FROM_SUBROUTINE,
    CST_OP_RETURN_FROM_INTERRUPT,
    CST_OP_WR_PC_LOW_BYTE,
    CST_OP_SET_TBLP,
    CST_OP_SET_TBHP,
    CST_OP_TABRD,
    CST_OP_TABLE_READ_LAST_PAGE
  } cst_op_t;

  // one decoded instruction, sampled only on the clock that ends the instruction cycle
  typedef struct packed {
    cst_op_t          op;
    logic [9:0]       target;   // jump or call address
    logic [7:0]       data;     // byte for pc low or pointers
    logic [7:0]       dest;     // data memory address for table reads
  } cst_cmd_t;

  // table read result towards data memory
  typedef struct packed {
    logic             we;
    logic [7:0]       addr;
    logic [7:0]       data;
  } cst_tbl_wr_t;

  // program memory load port
  typedef struct packed {
    logic             en;
    logic [9:0]       addr;
    logic [15:0]      data;
  } cst_pm_wr_t;

endpackage
